/* verilog/i2c_master_with_fifos.sv */
// two-wire bus master with four-byte receive and transmit fifos
// assumes a core-side special-function port on clk and open-drain
// pads that resolve scl/sda from the output enables
//
// Overview of operation
// - a write to the address register launches start and address phase.
// - address bits 7-1 are sent as the seven-bit target address.
// - address bit 0 picks read into receive fifo or write from transmit fifo.
// - a read stops after receive count plus one bytes, or on error.
// - status bit 7 shows link in use; transmit fifo drains meanwhile.
// - missing ack sets status bit 6 and halts; software writes zero to clear.
// - status bit 5 rises with receive data, clears when reads empty fifo.
// - status bit 4 rises when transmit fifo empties, cleared by a data write.
// - status bits 3-2 give active fifo level: 00 empty, 10 half, 11 full.
// - status bit 1 flags a write and read in the same cycle.
// - status bit 0 flags a data write into a full transmit fifo.
// - received bytes are acknowledged by hardware.
// - the last received byte gets a nack from hardware.
// - address rewrite mid-transfer ends with repeated start, not stop.
// - four-byte fifos each way; up to four bytes preloadable.
// - a write ends when the next byte is needed and fifo is empty.
// - a missing ack during a write ends the transfer and flushes the transmit fifo.
// - receive flag raised per byte or only when the fifo fills.
// - the link runs only while mode bit 7 is set.
// - bus clock is core clock over 16 times two to the divider field.
// - a select input hands the shared pins to this block or the other port.
`timescale 1ns/1ps
`include "i2c_map.svh"

module i2c_master_with_fifos (
   input  wire logic                 clk,              // core clock
   input  wire logic                 rst,              // async reset, high
   input  wire logic                 ce,               // clock enable, freezes all
   input  wire i2c_pkg::sfr_req_s    sfr_req,          // register access
   output logic [7:0]                sfr_rdata,        // read data, one cycle late
   input  wire logic                 pin_owner_select, // 1: pins belong to this block
   input  wire logic                 rx_irq_when_full, // 1: receive flag only on full
   input  wire logic                 scl_in,           // scl wire level
   input  wire logic                 sda_in,           // sda wire level
   output i2c_pkg::pin_drive_s       scl_drv,          // scl drive
   output i2c_pkg::pin_drive_s       sda_drv           // sda drive
);
   import i2c_pkg::*;
   // ----------------------------------------
   // register decode
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // two strobes at once is the collision case, so neither takes effect
   wire both      = sfr_req.wr & sfr_req.rd;
   wire wr_ok     = sfr_req.wr & ~both;
   wire rd_ok     = sfr_req.rd & ~both;
   wire wr_mode   = wr_ok & hit(sfr_req.addr, `OFS_MODE);
   wire wr_addr   = wr_ok & hit(sfr_req.addr, `OFS_ADDR);
   wire wr_stat   = wr_ok & hit(sfr_req.addr, `OFS_STAT);
   wire wr_tx     = wr_ok & hit(sfr_req.addr, `OFS_TX);
   wire rd_rx     = rd_ok & hit(sfr_req.addr, `OFS_RX);

   logic [7:0]  mode_reg;
   logic [7:0]  target_address_direction;
   wire         interface_enable   = mode_reg[`MODE_EN_BIT];
   wire  [1:0]  bus_clock_divider  = mode_reg[`MODE_DIV_HI:`MODE_DIV_LO];
   wire  [4:0]  receive_count      = mode_reg[`MODE_RCT_HI:0];
   wire         direction_select   = target_address_direction[0];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_reg                 <= `RST_BYTE;
         target_address_direction <= `RST_BYTE;
      end else if (ce) begin
         if (wr_mode)
            mode_reg <= sfr_req.wdata;
         if (wr_addr)
            target_address_direction <= sfr_req.wdata;
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] scl_sync, sda_sync;
   logic       scl_hi, sda_hi;

   // level changes only once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_hi   <= 1'b1;
         sda_hi   <= 1'b1;
      end else if (ce) begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         if (scl_sync[1] == scl_sync[2])
            scl_hi <= scl_sync[2];
         if (sda_sync[1] == sda_sync[2])
            sda_hi <= sda_sync[2];
      end
   end

   // ----------------------------------------
   // quarter-bit tick
   // ----------------------------------------
   // four ticks per scl period gives core/(16 * 2^div)
   logic [5:0] div_cnt;
   wire  [5:0] quarter_len = 6'(`QUARTER_CYC) << bus_clock_divider;
   wire        tick        = (div_cnt == quarter_len - 6'h1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         div_cnt <= 6'h0;
      else if (ce)
         div_cnt <= tick ? 6'h0 : div_cnt + 6'h1;
   end

   // ----------------------------------------
   // fifos
   // ----------------------------------------
   logic [7:0] tx_mem [0:3];
   logic [7:0] rx_mem [0:3];
   logic [1:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [2:0] tx_cnt, rx_cnt;
   wire        tx_full  = (tx_cnt == `FIFO_DEPTH);
   wire        tx_empty = (tx_cnt == 3'h0);
   wire        rx_full  = (rx_cnt == `FIFO_DEPTH);
   wire        rx_empty = (rx_cnt == 3'h0);
   logic       tx_pop, tx_flush, rx_push;
   logic [7:0] shift;
   wire        tx_push  = wr_tx & ~tx_full;
   wire        rx_pop   = rd_rx & ~rx_empty;

   always_ff @(posedge clk) begin
      if (ce & tx_push)
         tx_mem[tx_wp] <= sfr_req.wdata;
      if (ce & rx_push)
         rx_mem[rx_wp] <= shift;
   end
   // flush drops the transmit backlog after an error
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_wp  <= 2'h0;
         tx_rp  <= 2'h0;
         tx_cnt <= 3'h0;
      end else if (ce) begin
         if (tx_flush) begin
            tx_rp  <= tx_wp;
            tx_cnt <= 3'h0;
         end else begin
            tx_wp  <= tx_wp + 2'(tx_push);
            tx_rp  <= tx_rp + 2'(tx_pop);
            tx_cnt <= tx_cnt + 3'(tx_push) - 3'(tx_pop);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_wp  <= 2'h0;
         rx_rp  <= 2'h0;
         rx_cnt <= 3'h0;
      end else if (ce) begin
         rx_wp  <= rx_wp + 2'(rx_push);
         rx_rp  <= rx_rp + 2'(rx_pop);
         rx_cnt <= rx_cnt + 3'(rx_push) - 3'(rx_pop);
      end
   end

   // ----------------------------------------
   // link sequencer
   // ----------------------------------------
   link_state_e state;
   byte_kind_e  kind;
   logic [1:0]  q;
   logic [3:0]  bitn;
   logic [4:0]  rx_left;
   logic        ack_bad, pending, scl_low, sda_low, noack_set;

   // scl rising phase waits for the wire, so a slave may stretch
   wire step     = tick & ~(q == 2'h2 & ~scl_low & ~scl_hi);
   wire in_bit   = (state == ST_BIT);
   wire ack_slot = (bitn == `ACK_BIT);
   wire byte_end = in_bit & step & (q == 2'h3) & ack_slot;
   wire nack     = (kind != KIND_RX) & ack_bad;
   wire last_rx  = (rx_left == 5'h0);
   wire want_tx  = (kind == KIND_TX) | (kind == KIND_ADDR & ~direction_select);
   wire finish   = nack | ((kind == KIND_RX) ? last_rx : (want_tx & tx_empty));

   assign tx_pop    = byte_end & ~finish & want_tx;
   assign tx_flush  = byte_end & nack & want_tx;
   assign rx_push   = in_bit & step & (q == 2'h0) & ack_slot &
                      (kind == KIND_RX) & ~rx_full;
   assign noack_set = byte_end & nack;
   // address writes queue a launch; mid-transfer they become a restart
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         pending <= 1'b0;
      else if (ce) begin
         if (~interface_enable)
            pending <= 1'b0;
         else if (wr_addr)
            pending <= 1'b1;
         else if (state == ST_START & step & q == 2'h0)
            pending <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state   <= ST_IDLE;
         kind    <= KIND_ADDR;
         q       <= 2'h0;
         bitn    <= 4'h0;
         rx_left <= 5'h0;
         ack_bad <= 1'b0;
         shift   <= 8'h0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
      end else if (ce) begin
         if (~interface_enable) begin
            state   <= ST_IDLE;
            q       <= 2'h0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
         end else if (step) begin
            q <= q + 2'h1;
            case (state)
               ST_IDLE: begin
                  q <= 2'h0;
                  if (pending)
                     state <= ST_START;
               end
               ST_START: begin
                  case (q)
                     2'h0: begin
                        scl_low <= 1'b1;
                        sda_low <= 1'b0;
                     end
                     2'h1: scl_low <= 1'b0;
                     2'h2: sda_low <= 1'b1;
                     default: begin
                        scl_low <= 1'b1;
                        shift   <= target_address_direction;
                        kind    <= KIND_ADDR;
                        rx_left <= receive_count;
                        bitn    <= 4'h0;
                        state   <= ST_BIT;
                     end
                  endcase
               end
               ST_BIT: begin
                  case (q)
                     2'h0: begin
                        scl_low <= 1'b1;
                        if (~ack_slot)
                           sda_low <= (kind != KIND_RX) & ~shift[7];
                        else
                           sda_low <= (kind == KIND_RX) & ~last_rx;
                     end
                     2'h1: scl_low <= 1'b0;
                     2'h2: begin
                        if (~ack_slot)
                           shift <= {shift[6:0], sda_hi};
                        else
                           ack_bad <= sda_hi;
                     end
                     default: begin
                        scl_low <= 1'b1;
                        bitn    <= bitn + 4'h1;
                        if (ack_slot) begin
                           bitn <= 4'h0;
                           if (finish)
                              state <= pending ? ST_START : ST_STOP;
                           else if (want_tx) begin
                              kind  <= KIND_TX;
                              shift <= tx_mem[tx_rp];
                           end else begin
                              if (kind == KIND_RX)
                                 rx_left <= rx_left - 5'h1;
                              kind <= KIND_RX;
                           end
                        end
                     end
                  endcase
               end
               ST_STOP: begin
                  case (q)
                     2'h0: begin
                        scl_low <= 1'b1;
                        sda_low <= 1'b1;
                     end
                     2'h1: scl_low <= 1'b0;
                     2'h2: sda_low <= 1'b0;
                     default: state <= ST_IDLE;
                  endcase
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end
   // pins go quiet while the other serial port owns them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_drv <= '0;
         sda_drv <= '0;
      end else if (ce) begin
         scl_drv <= '{out: 1'b0, oe: scl_low & pin_owner_select};
         sda_drv <= '{out: 1'b0, oe: sda_low & pin_owner_select};
      end
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   logic link_in_use, missing_ack_flag, receive_irq_flag;
   logic transmit_irq_flag, access_collision_error, transmit_overfill_error;

   // flags set by hardware win over a clear in the same cycle
   wire rx_set   = rx_push & (~rx_irq_when_full | rx_cnt == 3'h3);
   wire rx_clr   = rx_pop & rx_cnt == 3'h1;
   wire tx_set   = tx_pop & tx_cnt == 3'h1 & ~tx_push;
   wire [1:0] tx_level = tx_empty ? `LEVEL_EMPTY : (tx_full ? `LEVEL_FULL : `LEVEL_HALF);
   wire [1:0] rx_level = rx_empty ? `LEVEL_EMPTY : (rx_full ? `LEVEL_FULL : `LEVEL_HALF);
   wire [1:0] fifo_level = direction_select ? rx_level : tx_level;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link_in_use             <= 1'b0;
         missing_ack_flag        <= 1'b0;
         receive_irq_flag        <= 1'b0;
         transmit_irq_flag       <= 1'b0;
         access_collision_error  <= 1'b0;
         transmit_overfill_error <= 1'b0;
      end else if (ce) begin
         link_in_use <= (state != ST_IDLE) | pending;
         missing_ack_flag <= noack_set |
            (missing_ack_flag & ~(wr_stat & ~sfr_req.wdata[`STAT_NOACK_BIT]));
         receive_irq_flag <= rx_set | (receive_irq_flag & ~rx_clr);
         transmit_irq_flag <= tx_set | (transmit_irq_flag & ~wr_tx);
         access_collision_error <= both |
            (access_collision_error & ~(wr_stat & ~sfr_req.wdata[`STAT_ACC_BIT]));
         transmit_overfill_error <= (wr_tx & tx_full) |
            (transmit_overfill_error & ~(wr_stat & ~sfr_req.wdata[`STAT_WRERR_BIT]));
      end
   end
   wire [7:0] interrupt_status_flags = {link_in_use, missing_ack_flag,
      receive_irq_flag, transmit_irq_flag, fifo_level,
      access_collision_error, transmit_overfill_error};

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // registered so the read port sees a clean byte; unmapped reads give zero
   wire [7:0] rd_sel = hit(sfr_req.addr, `OFS_MODE) ? mode_reg :
                       hit(sfr_req.addr, `OFS_ADDR) ? target_address_direction :
                       hit(sfr_req.addr, `OFS_STAT) ? interrupt_status_flags :
                       hit(sfr_req.addr, `OFS_RX)   ? rx_mem[rx_rp] : 8'h00;

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         sfr_rdata <= 8'h00;
      else if (ce & rd_ok)
         sfr_rdata <= rd_sel;
   end

endmodule

/* verilog/i2c_map.svh */
// register offsets, field positions, reset values and bit timing
// for the two-wire master; included by the design file and the checker
`ifndef I2C_MAP_SVH
`define I2C_MAP_SVH

// ----------------------------------------
// register offsets on the special-function port
// ----------------------------------------
`define OFS_TX            8'h9A
`define OFS_RX            8'h9B
`define OFS_MODE          8'hE8
`define OFS_ADDR          8'hE9
`define OFS_STAT          8'hEA

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define RST_BYTE          8'h00
`define MODE_EN_BIT       7
`define MODE_DIV_HI       6
`define MODE_DIV_LO       5
`define MODE_RCT_HI       4
`define STAT_NOACK_BIT    6
`define STAT_ACC_BIT      1
`define STAT_WRERR_BIT    0
`define LEVEL_EMPTY       2'h0
`define LEVEL_HALF        2'h2
`define LEVEL_FULL        2'h3

// ----------------------------------------
// fifo depth and bus clock division
// ----------------------------------------
`define FIFO_DEPTH        3'h4
`define SCL_DIV_BASE      16
`define QUARTER_CYC       (`SCL_DIV_BASE / 4)
`define ACK_BIT           4'h8

`endif

/* verilog/i2c_pkg.sv */
// types shared by the two-wire master and its bench
// assumes the map header carries every number
package i2c_pkg;

   // ----------------------------------------
   // link sequencer states, one-hot
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_START = 4'h2,
      ST_BIT   = 4'h4,
      ST_STOP  = 4'h8
   } link_state_e;

   // ----------------------------------------
   // kind of byte being shifted, one-hot
   // ----------------------------------------
   typedef enum logic [2:0] {
      KIND_ADDR = 3'h1,
      KIND_TX   = 3'h2,
      KIND_RX   = 3'h4
   } byte_kind_e;

   // one access on the special-function port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;

   // open-drain pin drive: oe high pulls the wire low
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_s;

endpackage

/* sim/i2c_slave_model.sv */
// two-wire slave model answering at one address
// assumes scl and sda are wired-and levels with pull-ups
`timescale 1ns/1ps

module i2c_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A     // address we answer to
) (
   input  wire logic       scl,           // clock wire
   input  wire logic       sda,           // data wire
   input  wire logic       stretch,       // slow mode: hold scl low
   output logic            scl_oe,        // pulls scl low
   output logic            sda_oe,        // pulls sda low
   output logic [7:0]      adr_byte,      // last address byte
   output logic [7:0]      last_wr,       // last byte written to us
   output logic [7:0]      n_wr,          // bytes written to us
   output logic [7:0]      n_start,       // starts seen
   output logic [7:0]      n_stop,        // stops seen
   output logic [7:0]      n_ack,         // master acks
   output logic [7:0]      n_nack         // master nacks
);
   logic [3:0] cnt;
   logic [7:0] sh, tx, nxt;
   logic       act, first, rd_mode, hit, snd, more;

   initial begin
      {scl_oe, sda_oe, act, snd, n_wr, n_start, n_stop, n_ack, n_nack} = '0;
      nxt = 8'hC0;
   end
   // start and stop are the only sda moves while scl is high
   always @(negedge sda) if (scl === 1'h1) begin
      n_start++;
      {act, first, cnt, snd} = {1'h1, 1'h1, 4'h0, 1'h0};
   end
   always @(posedge sda) if (scl === 1'h1 && act) begin
      n_stop++;
      {act, sda_oe} = 2'h0;
   end
   // sample data bits, then the master's ack of a byte we sent
   always @(posedge scl) if (act) begin
      cnt++;
      if (cnt <= 8) sh = {sh[6:0], sda};
      else if (snd) begin
         more = !sda;
         if (sda) n_nack++;
         else n_ack++;
      end
   end
   // drive only after scl falls so data never moves while scl is high
   always @(negedge scl) if (act) begin
      if (cnt == 8) begin
         if (first) begin
            adr_byte = sh;
            rd_mode = sh[0];
            hit = sh[7:1] == ADDR;
            sda_oe = hit;
         end else if (!rd_mode) begin
            n_wr++;
            last_wr = sh;
            sda_oe = 1;
         end else sda_oe = 0;
      end else if (cnt == 9) begin
         cnt = 0;
         snd = rd_mode && hit && (first || more);
         first = 0;
         tx = nxt;
         if (snd) nxt++;
         sda_oe = snd && !tx[7];
      end else if (cnt != 0 && snd) begin
         tx = tx << 1;
         sda_oe = !tx[7];
      end
   end
   // a slow slave holds scl low, so the master must wait for the wire
   always @(negedge scl) if (stretch && act) begin
      scl_oe = 1;
      #250 scl_oe = 0;
   end
endmodule

/* sim/i2c_master_with_fifos_checker.sv */
// assertions on the ports of the two-wire master
// assumes the smallest divider, four cycles a quarter, is the fastest
`timescale 1ns/1ps
`include "i2c_map.svh"

module i2c_master_with_fifos_checker (
   input wire logic                clk,              // core clock
   input wire logic                rst,              // async reset
   input wire logic                ce,               // clock enable
   input wire i2c_pkg::sfr_req_s   sfr_req,          // register access
   input wire logic [7:0]          sfr_rdata,        // read data
   input wire logic                pin_owner_select, // pin owner
   input wire logic                rx_irq_when_full, // rx flag mode
   input wire logic                scl_in,           // scl wire
   input wire logic                sda_in,           // sda wire
   input wire i2c_pkg::pin_drive_s scl_drv,          // scl drive
   input wire i2c_pkg::pin_drive_s sda_drv           // sda drive
);
   import i2c_pkg::*;
   logic mode_en;
   // decoded accesses; a collision performs neither half
   wire  wr_only = ce && sfr_req.wr && !sfr_req.rd;
   wire  rd_stat = ce && sfr_req.rd && !sfr_req.wr && sfr_req.addr == `OFS_STAT;
   wire  wr_adr  = wr_only && sfr_req.addr == `OFS_ADDR;
   wire  clr_all = wr_only && sfr_req.addr == `OFS_STAT && sfr_req.wdata == 8'h00;
   wire  both    = ce && sfr_req.wr && sfr_req.rd;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // shadow of the enable bit so link activity can be judged
   always_ff @(posedge clk or posedge rst) begin
      if (rst) mode_en <= 1'h0;
      else if (wr_only && sfr_req.addr == `OFS_MODE) mode_en <= sfr_req.wdata[`MODE_EN_BIT];
   end

   // wire-level timing and register answers
   property p_owner; !pin_owner_select [*2] |-> !scl_drv.oe && !sda_drv.oe; endproperty
   a_owner: assert property (p_owner) else $error("pins driven while not owned");
   property p_quarter; $changed(scl_drv.oe) |=> $stable(scl_drv.oe) [*3]; endproperty
   a_quarter: assert property (p_quarter) else $error("scl phase shorter than a quarter");
   property p_start; $rose(sda_drv.oe) && !scl_drv.oe |-> (sda_drv.oe && !scl_drv.oe) [*4]; endproperty
   a_start: assert property (p_start) else $error("start hold too short");
   property p_stop; $fell(sda_drv.oe) && !scl_drv.oe |-> (!sda_drv.oe && !scl_drv.oe) [*8]; endproperty
   a_stop: assert property (p_stop) else $error("bus not idle after stop");
   property p_busy; wr_adr && mode_en ##3 rd_stat |=> sfr_rdata[7]; endproperty
   a_busy: assert property (p_busy) else $error("busy not shown after launch");
   property p_clear; clr_all ##2 rd_stat |=> !sfr_rdata[6] && sfr_rdata[1:0] == 2'h0; endproperty
   a_clear: assert property (p_clear) else $error("error flags not cleared");
   property p_coll; both ##[2:3] rd_stat |=> sfr_rdata[1]; endproperty
   a_coll: assert property (p_coll) else $error("collision flag missing");
   property p_off; !mode_en [*3] |-> !scl_drv.oe && !sda_drv.oe; endproperty
   a_off: assert property (p_off) else $error("bus driven while disabled");
endmodule

bind i2c_master_with_fifos i2c_master_with_fifos_checker i2c_master_with_fifos_checker_i (
   .clk(clk), .rst(rst), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .pin_owner_select(pin_owner_select), .rx_irq_when_full(rx_irq_when_full),
   .scl_in(scl_in), .sda_in(sda_in), .scl_drv(scl_drv), .sda_drv(sda_drv));

/* sim/testbench.sv */
// self-checking bench for the two-wire master with fifos
// assumes the slave model on pulled-up wires and the bound checker
`timescale 1ns/1ps

module testbench;
   import i2c_pkg::*;
   typedef struct packed {logic w; logic [7:0] a, d, e;} row_s;
   logic       clk, rst, ce, owner, rx_full, stretch, s_scl_oe, s_sda_oe;
   logic [7:0] sfr_rdata, got, junk, adr_byte, last_wr, n_wr, n_start, n_stop, n_ack, n_nack;
   sfr_req_s   sfr_req;
   pin_drive_s scl_drv, sda_drv;
   int         miscompares, n_tests, cycles;
   row_s       rows [5];
   // open-drain wires: released means pulled up
   wire        scl = !(scl_drv.oe || s_scl_oe);
   wire        sda = !(sda_drv.oe || s_sda_oe);

   i2c_master_with_fifos i2c_master_with_fifos_i (
      .clk(clk), .rst(rst), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .pin_owner_select(owner), .rx_irq_when_full(rx_full), .scl_in(scl), .sda_in(sda),
      .scl_drv(scl_drv), .sda_drv(sda_drv));
   i2c_slave_model i2c_slave_model_i (
      .scl(scl), .sda(sda), .stretch(stretch), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe),
      .adr_byte(adr_byte), .last_wr(last_wr), .n_wr(n_wr), .n_start(n_start),
      .n_stop(n_stop), .n_ack(n_ack), .n_nack(n_nack));

   always #5 clk = ~clk;
   // a hang ends the run as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         stop_test();
      end
   end

   // one access: strobe over one rising edge, then an idle cycle
   task automatic acc(input logic w, r, input logic [7:0] a, wd, output logic [7:0] d);
      sfr_req = '{w, r, a, wd};
      @(negedge clk);
      sfr_req = '0;
      @(negedge clk);
      d = sfr_rdata;
   endtask
   task automatic wr(input logic [7:0] a, d);
      acc(1'h1, 1'h0, a, d, junk);
   endtask
   task automatic rd(input logic [7:0] a);
      acc(1'h0, 1'h1, a, 8'h00, got);
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   // poll busy with a bound of 300 polls, so a stuck flag ends the wait, not the run
   task automatic wait_idle;
      got = 8'h80;
      for (int k = 0; k < 300 && got[7] === 1'h1; k++) begin
         repeat (10) @(negedge clk);
         rd(8'hEA);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      {clk, rst, ce, owner, rx_full, stretch} = 6'h1C;
      sfr_req = '0;
      rows = '{'{1'h0, 8'hEA, 8'h00, 8'h00}, '{1'h0, 8'hE9, 8'h00, 8'h00}, '{1'h0, 8'hE8, 8'h00, 8'h00},
               '{1'h0, 8'h55, 8'h00, 8'h00}, '{1'h1, 8'hE8, 8'h81, 8'h81}};
      repeat (10) @(negedge clk);
      rst = 0;
      // reset values, an unmapped read, then enable with a two-byte count
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk("register row", rows[i].e, got);
      end
      $display("register rows done");
      // preload four, a fifth overfills, then all four go out
      for (int i = 0; i < 5; i++) wr(8'h9A, 8'hA0 + 8'(i));
      rd(8'hEA);
      chk("status full", 8'h0D, got);
      wr(8'hEA, 8'h00);
      wr(8'hE9, 8'h54);
      @(negedge clk);
      rd(8'hEA);
      chk("busy", 8'h80, got & 8'h80);
      wait_idle();
      chk("address byte", 8'h54, adr_byte);
      chk("bytes sent", 8'h04, n_wr);
      chk("last byte", 8'hA3, last_wr);
      chk("stop", 8'h01, n_stop);
      rd(8'hEA);
      chk("tx empty", 8'h10, got);
      wr(8'h9A, 8'h77);
      rd(8'hEA);
      chk("tx flag clear", 8'h00, got & 8'h10);
      $display("write test done");
      // unknown address: flag, flushed fifo; then a collision
      wr(8'hE9, 8'h22);
      wait_idle();
      rd(8'hEA);
      chk("nack status", 8'h40, got & 8'hCD);
      chk("nothing sent", 8'h04, n_wr);
      wr(8'hEA, 8'h00);
      rd(8'hEA);
      chk("nack clear", 8'h00, got & 8'h40);
      acc(1'h1, 1'h1, 8'hEA, 8'h00, junk);
      rd(8'hEA);
      chk("collision", 8'h02, got & 8'h02);
      wr(8'hEA, 8'h00);
      $display("error tests done");
      // read two bytes: hardware acks the first, nacks the last
      wr(8'hE9, 8'h55);
      wait_idle();
      chk("master acks", 8'h01, n_ack);
      chk("master nacks", 8'h01, n_nack);
      for (int i = 0; i < 2; i++) begin
         rd(8'hEA);
         chk("rx flag", 8'h20, got & 8'h20);
         rd(8'h9B);
         chk("rx data", 8'hC0 + 8'(i), got);
      end
      rd(8'hEA);
      chk("rx flag clear", 8'h00, got & 8'h20);
      $display("read test done");
      // rewrite mid-read with a slow slave: repeated start, fifo fills
      {rx_full, stretch} = 2'h3;
      wr(8'hE8, 8'hA1);
      wr(8'hE9, 8'h55);
      repeat (200) @(negedge clk);
      wr(8'hE9, 8'h55);
      wait_idle();
      chk("starts", 8'h05, n_start);
      chk("stops", 8'h04, n_stop);
      rd(8'hEA);
      chk("rx full", 8'h2C, got & 8'h2C);
      for (int i = 0; i < 4; i++) begin
         rd(8'h9B);
         chk("rx data", 8'hC2 + 8'(i), got);
      end
      $display("repeated start test done");
      // disabled and pins handed away: nothing reaches the bus
      owner = 0;
      wr(8'hE9, 8'h54);
      wait_idle();
      chk("no start", 8'h05, n_start);
      owner = 1;
      wr(8'hE8, 8'h01);
      wr(8'hE9, 8'h54);
      repeat (300) @(negedge clk);
      chk("no start", 8'h05, n_start);
      ce = 0;
      wr(8'hE8, 8'h81);
      ce = 1;
      rd(8'hE8);
      chk("frozen mode", 8'h01, got);
      $display("disable test done");
      stop_test();
   end
endmodule
